/* File: design/vxs_ctrl.sv */
// top of the slot-0 bus, trigger and clock source controller
`timescale 1ns/1ps
module vxs_ctrl
  import vxs_pkg::*;
#(
  parameter int TICK_CYC = CYC_PER_US
)(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [AW-1:0]     reg_addr,
  input  wire logic [DW-1:0]     reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DW-1:0]     reg_rdata,
  output logic                   irq,
  input  wire logic              mst_need,
  input  wire logic              mst_done,
  input  wire logic              acc_start,
  input  wire logic              slave_ack,
  output logic                   acc_berr,
  output logic                   mst_owns,
  input  wire logic [NREQ-1:0]   br_in,
  input  wire logic              bbsy_in,
  output logic      [NREQ-1:0]   br_out,
  output logic                   bbsy_out,
  output logic      [NREQ-1:0]   bg_out,
  input  wire logic [NLINES-1:0] ttl_in,
  output logic      [NLINES-1:0] ttl_out,
  output logic      [NLINES-1:0] ttl_oe,
  input  wire logic [NLINES-1:0] lxi_in,
  output logic      [NLINES-1:0] lxi_out,
  output logic      [NLINES-1:0] lxi_oe,
  output logic      [NLINES-1:0] lxi_bias_en,
  input  wire logic              slot0,
  output logic                   clkgen_en,
  output logic                   clk10_from_fp,
  output logic                   clk10_drv_en,
  output logic                   fp_clk_oe
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0]          tmo_sel;
    logic [1:0]          arb_mode;
    logic                fair;
    logic                release_when_done;
    logic                clk_in;
    logic [1:0]          level;
    logic [2*NLINES-1:0] map;
    logic [2*NLINES-1:0] drv;
    logic [NLINES-1:0]   bias;
    logic [NLINES-1:0]   force_on;
    logic [IRQ_W-1:0]    irq_stat;
    logic [IRQ_W-1:0]    irq_mask;
    logic [DW-1:0]       rdata;
    logic [NREQ-1:0]     br_vec;
    logic                own;
    logic                fair_block;
    logic [NLINES-1:0]   lxi_q;
    logic [NLINES-1:0]   ttl_oe;
    logic [NLINES-1:0]   lxi_out;
    logic [NLINES-1:0]   lxi_oe;
    logic [NLINES-1:0]   bias_en;
    logic                clkgen_en;
    logic                clk10_from_fp;
    logic                clk10_drv_en;
    logic                fp_clk_oe;
  } vxs_top_s;

  vxs_top_s          s;
  vxs_top_s          next_s;
  logic [1:0]        rst_q;
  logic              rst_n;
  logic [NLINES-1:0] next_ttl_oe;
  logic [NLINES-1:0] next_lxi_out;
  logic [NLINES-1:0] next_lxi_oe;
  logic [NLINES-1:0] next_bias_en;
  logic [IRQ_W-1:0]  ev;
  logic              ext_req;
  logic              granted;

  vxs_link_if lk ();

  // ------------------------------------------------------------
  // reset release through two flops
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rst_q <= 2'b00;
    else
      rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  // ------------------------------------------------------------
  // timer and arbiter
  // ------------------------------------------------------------
  assign lk.acc_start = acc_start;
  assign lk.slave_ack = slave_ack;
  assign lk.tmo_sel   = s.tmo_sel;
  assign lk.req       = br_in | s.br_vec;
  assign lk.busy      = bbsy_in | s.own;
  assign lk.arb_mode  = vxs_arb_e'(s.arb_mode);

  vxs_bus_timer #(.TICK_CYC(TICK_CYC)) u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .lk    (lk.tmr)
  );

  vxs_arbiter u_arb (
    .clk   (clk),
    .rst_n (rst_n),
    .lk    (lk.arb)
  );

  // ------------------------------------------------------------
  // per line trigger routing and driver control
  // ------------------------------------------------------------
  generate
    for (genvar i = 0; i < NLINES; i++)
    begin : g_line
      logic [1:0] map_i;
      logic [1:0] drv_i;
      logic       val;
      assign map_i = s.map[2*i +: 2];
      assign drv_i = s.drv[2*i +: 2];
      assign val = ((map_i == MAP_TTL2LXI) && (ttl_in[i] == TTL_ACT_LVL)) || s.force_on[i];
      assign next_ttl_oe[i]  = (map_i == MAP_LXI2TTL) && lxi_in[i];
      assign next_lxi_out[i] = (drv_i == DRV_WOR) ? 1'b1 : val;
      assign next_lxi_oe[i]  = (drv_i == DRV_PUSH) || ((drv_i == DRV_WOR) && val);
      assign next_bias_en[i] = (drv_i == DRV_WOR) && s.bias[i];
    end
  endgenerate

  // events: bus error and any panel line change
  assign ev[IRQ_BERR_BIT] = lk.berr;
  assign ev[IRQ_TRIG_BIT] = |(lxi_in ^ s.lxi_q);
  assign ext_req          = |br_in;
  assign granted          = lk.grant[s.level];

  // ------------------------------------------------------------
  // registers, requester and clock source
  // ------------------------------------------------------------
  always_comb
  begin
    logic [IRQ_W-1:0] clr;
    logic             req_now;
    next_s       = s;
    clr          = '0;
    next_s.lxi_q = lxi_in;
    next_s.rdata = RST_ZERO;
    if (reg_wr)
    begin
      case (reg_addr)
        REG_CFG:
        begin
          next_s.tmo_sel  = reg_wdata[CFG_TMO_LSB +: 3];
          next_s.arb_mode = reg_wdata[CFG_ARB_LSB +: 2];
          next_s.fair     = reg_wdata[CFG_FAIR_BIT];
          next_s.release_when_done      = reg_wdata[CFG_RWD_BIT];
          next_s.clk_in   = reg_wdata[CFG_CLKIN_BIT];
          next_s.level    = reg_wdata[CFG_LVL_LSB +: 2];
        end
        REG_MAP:      next_s.map      = reg_wdata[2*NLINES-1:0];
        REG_DRV:      next_s.drv      = reg_wdata[2*NLINES-1:0];
        REG_CTRL:
        begin
          next_s.bias     = reg_wdata[CTRL_BIAS_LSB +: NLINES];
          next_s.force_on = reg_wdata[CTRL_FORCE_LSB +: NLINES];
        end
        REG_IRQ_STAT: clr             = reg_wdata[IRQ_W-1:0];
        REG_IRQ_MASK: next_s.irq_mask = reg_wdata[IRQ_W-1:0];
        default:      clr             = '0;
      endcase
    end
    // set beats a same-cycle clear
    next_s.irq_stat = (s.irq_stat & ~clr) | ev;
    if (reg_rd)
    begin
      case (reg_addr)
        REG_CFG:
        begin
          next_s.rdata[CFG_TMO_LSB +: 3] = s.tmo_sel;
          next_s.rdata[CFG_ARB_LSB +: 2] = s.arb_mode;
          next_s.rdata[CFG_FAIR_BIT]     = s.fair;
          next_s.rdata[CFG_RWD_BIT]      = s.release_when_done;
          next_s.rdata[CFG_CLKIN_BIT]    = s.clk_in;
          next_s.rdata[CFG_LVL_LSB +: 2] = s.level;
        end
        REG_MAP:      next_s.rdata[2*NLINES-1:0] = s.map;
        REG_DRV:      next_s.rdata[2*NLINES-1:0] = s.drv;
        REG_CTRL:
        begin
          next_s.rdata[CTRL_BIAS_LSB +: NLINES]  = s.bias;
          next_s.rdata[CTRL_FORCE_LSB +: NLINES] = s.force_on;
        end
        REG_STATUS:
        begin
          next_s.rdata[NLINES-1:0]  = lxi_in;
          next_s.rdata[ST_SLOT0_BIT] = slot0;
          next_s.rdata[ST_OWN_BIT]   = s.own;
        end
        REG_IRQ_STAT: next_s.rdata[IRQ_W-1:0] = s.irq_stat;
        REG_IRQ_MASK: next_s.rdata[IRQ_W-1:0] = s.irq_mask;
        default:      next_s.rdata = RST_ZERO;
      endcase
    end
    // take the bus on our grant
    if (!s.own && granted && (s.br_vec != '0))
    begin
      next_s.own        = 1'b1;
      next_s.fair_block = 1'b1;
    end
    else if (s.own && s.release_when_done && (mst_done || !mst_need))
      next_s.own = 1'b0;
    else if (s.own && !s.release_when_done && !mst_need && ext_req)
      next_s.own = 1'b0;
    // fair waits until others are served
    if (!ext_req && !next_s.own)
      next_s.fair_block = 1'b0;
    req_now = mst_need && !next_s.own && !(s.fair && s.fair_block);
    next_s.br_vec = '0;
    next_s.br_vec[s.level] = req_now;
    next_s.ttl_oe  = next_ttl_oe;
    next_s.lxi_out = next_lxi_out;
    next_s.lxi_oe  = next_lxi_oe;
    next_s.bias_en = next_bias_en;
    // clock choice only in slot 0
    next_s.clk10_drv_en  = slot0;
    next_s.clkgen_en     = !(slot0 && s.clk_in);
    next_s.clk10_from_fp = slot0 && s.clk_in;
    next_s.fp_clk_oe     = slot0 && !s.clk_in;
  end

  // state register, config resets to zero values
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata     = s.rdata;
  assign irq           = |(s.irq_stat & s.irq_mask);
  assign acc_berr      = lk.berr;
  assign mst_owns      = s.own;
  assign bbsy_out      = s.own;
  assign br_out        = s.br_vec;
  assign bg_out        = lk.grant;
  assign ttl_out       = {NLINES{TTL_ACT_LVL}};
  assign ttl_oe        = s.ttl_oe;
  assign lxi_out       = s.lxi_out;
  assign lxi_oe        = s.lxi_oe;
  assign lxi_bias_en   = s.bias_en;
  assign clkgen_en     = s.clkgen_en;
  assign clk10_from_fp = s.clk10_from_fp;
  assign clk10_drv_en  = s.clk10_drv_en;
  assign fp_clk_oe     = s.fp_clk_oe;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // bus error reaches status
  property p_berr_sticky;
    @(posedge clk) disable iff (!rst_n)
    lk.berr |=> s.irq_stat[IRQ_BERR_BIT] [*2];
  endproperty
  a_berr_sticky: assert property (p_berr_sticky) else $error("bus error not held");

  property p_lxi2ttl;
    @(posedge clk) disable iff (!rst_n)
    (s.map[1:0] == MAP_LXI2TTL) |=> (s.ttl_oe[0] == $past(lxi_in[0]));
  endproperty
  a_lxi2ttl: assert property (p_lxi2ttl) else $error("panel to backplane broken");

  property p_drv_off;
    @(posedge clk) disable iff (!rst_n)
    (s.drv[1:0] == DRV_OFF) |=> !s.lxi_oe[0];
  endproperty
  a_drv_off: assert property (p_drv_off) else $error("disabled driver enabled");

  property p_wor_high;
    @(posedge clk) disable iff (!rst_n)
    (s.drv[1:0] == DRV_WOR) |=> (!s.lxi_oe[0] || s.lxi_out[0]);
  endproperty
  a_wor_high: assert property (p_wor_high) else $error("wired-or drove low");

  property p_bias;
    @(posedge clk) disable iff (!rst_n)
    ##1 (s.bias_en[0] == $past(s.drv[1:0] == DRV_WOR && s.bias[0]));
  endproperty
  a_bias: assert property (p_bias) else $error("bias mismatch");

  property p_force;
    @(posedge clk) disable iff (!rst_n)
    (s.force_on[0] && s.drv[1:0] == DRV_PUSH) |=> (s.lxi_oe[0] && s.lxi_out[0]);
  endproperty
  a_force: assert property (p_force) else $error("force not applied");

  property p_status;
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == REG_STATUS) |=> (s.rdata[NLINES-1:0] == $past(lxi_in));
  endproperty
  a_status: assert property (p_status) else $error("status not live level");

  property p_clk_in;
    @(posedge clk) disable iff (!rst_n)
    (slot0 && s.clk_in) |=> (!s.clkgen_en && s.clk10_from_fp && !s.fp_clk_oe);
  endproperty
  a_clk_in: assert property (p_clk_in) else $error("input clock mode wrong");

  property p_clk_out;
    @(posedge clk) disable iff (!rst_n)
    (slot0 && !s.clk_in) |=> (s.clkgen_en && s.fp_clk_oe && s.clk10_drv_en);
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("output clock mode wrong");

  property p_not_slot0;
    @(posedge clk) disable iff (!rst_n)
    !slot0 |=> (!s.clk10_drv_en && !s.clk10_from_fp && !s.fp_clk_oe);
  endproperty
  a_not_slot0: assert property (p_not_slot0) else $error("clock driven off slot 0");

  property p_rwd;
    @(posedge clk) disable iff (!rst_n)
    (s.own && s.release_when_done && mst_done) |=> !s.own;
  endproperty
  a_rwd: assert property (p_rwd) else $error("bus kept after done");

  property p_fair;
    @(posedge clk) disable iff (!rst_n)
    (s.fair && s.fair_block && ext_req) |=> (s.br_vec == '0);
  endproperty
  a_fair: assert property (p_fair) else $error("fair request not held back");

endmodule // vxs_ctrl

/* File: design/vxs_pkg.sv */
// shared constants, register map and types of the slot-0 bus and trigger controller
package vxs_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int US_NS         = 1000;
  localparam int CYC_PER_US    = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int NLINES = 8;
  localparam int NREQ   = 4;
  localparam int AW     = 5;
  localparam int DW     = 32;
  localparam int TMO_W  = 12;
  localparam int IRQ_W  = 2;

  // ------------------------------------------------------------
  // register offsets and fields
  // ------------------------------------------------------------
  localparam logic [AW-1:0] REG_CFG      = 5'h00;
  localparam logic [AW-1:0] REG_MAP      = 5'h04;
  localparam logic [AW-1:0] REG_DRV      = 5'h08;
  localparam logic [AW-1:0] REG_CTRL     = 5'h0C;
  localparam logic [AW-1:0] REG_STATUS   = 5'h10;
  localparam logic [AW-1:0] REG_IRQ_STAT = 5'h14;
  localparam logic [AW-1:0] REG_IRQ_MASK = 5'h18;
  localparam int CFG_TMO_LSB    = 0;
  localparam int CFG_ARB_LSB    = 4;
  localparam int CFG_FAIR_BIT   = 8;
  localparam int CFG_RWD_BIT    = 9;
  localparam int CFG_CLKIN_BIT  = 12;
  localparam int CFG_LVL_LSB    = 14;
  localparam int CTRL_BIAS_LSB  = 0;
  localparam int CTRL_FORCE_LSB = 8;
  localparam int ST_SLOT0_BIT   = 8;
  localparam int ST_OWN_BIT     = 9;
  localparam int IRQ_BERR_BIT   = 0;
  localparam int IRQ_TRIG_BIT   = 1;
  localparam logic TTL_ACT_LVL  = 1'b0;
  localparam logic [DW-1:0] RST_ZERO = 32'h0000_0000;

  // ------------------------------------------------------------
  // modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ARB_PRI = 2'b00, ARB_SGL = 2'b01, ARB_RRS = 2'b10} vxs_arb_e;
  typedef enum logic [1:0] {MAP_OFF = 2'b00, MAP_LXI2TTL = 2'b01, MAP_TTL2LXI = 2'b10} vxs_map_e;
  typedef enum logic [1:0] {DRV_OFF = 2'b00, DRV_PUSH = 2'b01, DRV_WOR = 2'b10} vxs_drv_e;

  // bus timeout in microseconds per setting
  function automatic logic [TMO_W-1:0] vxs_tmo_us(input logic [2:0] sel);
    case (sel)
      3'h0:    return 12'h010;
      3'h1:    return 12'h020;
      3'h2:    return 12'h040;
      3'h3:    return 12'h080;
      3'h4:    return 12'h100;
      3'h5:    return 12'h200;
      3'h6:    return 12'h401;
      default: return 12'h800;
    endcase
  endfunction

endpackage

/* File: design/vxs_link_if.sv */
// internal carrier between top, bus timer and arbiter
`timescale 1ns/1ps
interface vxs_link_if;
  import vxs_pkg::*;
  logic            acc_start;
  logic            slave_ack;
  logic            berr;
  logic [2:0]      tmo_sel;
  logic [NREQ-1:0] req;
  logic [NREQ-1:0] grant;
  logic            busy;
  vxs_arb_e        arb_mode;
  modport top (output acc_start, slave_ack, tmo_sel, req, busy, arb_mode, input berr, grant);
  modport tmr (input acc_start, slave_ack, tmo_sel, output berr);
  modport arb (input req, busy, arb_mode, output grant);
endinterface

/* File: design/vxs_bus_timer.sv */
// bus timer: flags a bus error when a slave does not answer in time
`timescale 1ns/1ps
module vxs_bus_timer
  import vxs_pkg::*;
#(
  parameter int TICK_CYC = CYC_PER_US
)(
  input  wire logic clk,
  input  wire logic rst_n,
  vxs_link_if.tmr   lk
);

  typedef struct packed {
    logic             run;
    logic [15:0]      pre;
    logic [TMO_W-1:0] us;
    logic             berr;
  } vxs_tmr_s;

  vxs_tmr_s s;
  vxs_tmr_s next_s;
  logic [TMO_W-1:0] limit;
  logic             tick;

  assign limit   = vxs_tmo_us(lk.tmo_sel);
  assign tick    = (s.pre == 16'(TICK_CYC - 1));
  assign lk.berr = s.berr;

  // ------------------------------------------------------------
  // timer state
  // ------------------------------------------------------------
  always_comb
  begin
    next_s      = s;
    next_s.berr = 1'b0;
    if (lk.acc_start)
    begin
      next_s.run = 1'b1;
      next_s.pre = '0;
      next_s.us  = '0;
    end
    else if (s.run)
    begin
      if (lk.slave_ack)
        next_s.run = 1'b0;
      else if (tick)
      begin
        next_s.pre = '0;
        next_s.us  = s.us + 1'b1;
        if (s.us + 1'b1 == limit)
        begin
          next_s.run  = 1'b0;
          next_s.berr = 1'b1;
        end
      end
      else
        next_s.pre = s.pre + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  property p_expire_at_limit;
    @(posedge clk) disable iff (!rst_n)
    (s.run && !lk.acc_start && !lk.slave_ack && tick && s.us + 1'b1 == limit) |=> s.berr;
  endproperty
  a_expire_at_limit: assert property (p_expire_at_limit) else $error("timer missed expiry");

  property p_ack_stops;
    @(posedge clk) disable iff (!rst_n)
    (s.run && lk.slave_ack && !lk.acc_start) |=> !s.berr && !s.run;
  endproperty
  a_ack_stops: assert property (p_ack_stops) else $error("bus error after slave answer");

endmodule // vxs_bus_timer

/* File: design/vxs_arbiter.sv */
// system bus arbiter with priority, single level and round robin modes
`timescale 1ns/1ps
module vxs_arbiter
  import vxs_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  vxs_link_if.arb   lk
);

  typedef struct packed {
    logic [NREQ-1:0] grant;
    logic [1:0]      last;
  } vxs_arb_s;

  vxs_arb_s s;
  vxs_arb_s next_s;

  assign lk.grant = s.grant;

  // ------------------------------------------------------------
  // grant selection, only while the bus is free
  // ------------------------------------------------------------
  always_comb
  begin
    logic found;
    int   idx;
    next_s = s;
    found  = 1'b0;
    idx    = 0;
    if (s.grant != '0)
    begin
      // drop grant once its request goes away
      if ((lk.req & s.grant) == '0)
        next_s.grant = '0;
    end
    else if (!lk.busy && lk.req != '0)
    begin
      case (lk.arb_mode)
        ARB_SGL:
        begin
          found = lk.req[NREQ-1];
          idx   = NREQ - 1;
        end
        ARB_RRS:
        begin
          for (int k = 1; k <= NREQ; k++)
          begin
            if (!found && lk.req[(int'(s.last) + k) % NREQ])
            begin
              found = 1'b1;
              idx   = (int'(s.last) + k) % NREQ;
            end
          end
        end
        default:
        begin
          for (int k = 0; k < NREQ; k++)
          begin
            if (lk.req[k])
            begin
              found = 1'b1;
              idx   = k;
            end
          end
        end
      endcase
      if (found)
      begin
        next_s.grant      = '0;
        next_s.grant[idx] = 1'b1;
        next_s.last       = 2'(idx);
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  property p_sgl_top;
    @(posedge clk) disable iff (!rst_n)
    ($rose(|s.grant) && $past(lk.arb_mode) == ARB_SGL) |-> s.grant[NREQ-1];
  endproperty
  a_sgl_top: assert property (p_sgl_top) else $error("single level grant below top");

  property p_one_grant;
    @(posedge clk) disable iff (!rst_n)
    $onehot0(s.grant) && (!$rose(|s.grant) || $past(!lk.busy));
  endproperty
  a_one_grant: assert property (p_one_grant) else $error("bad grant vector");

endmodule // vxs_arbiter

/* File: test/vxs_slave_model.sv */
// stand-in bus slave that answers a master access or stays silent
`timescale 1ns/1ps
module vxs_slave_model
  import vxs_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic acc_start,
  input  wire logic mute,
  output logic      slave_ack
);
  logic [2:0] dly;
  // answer four cycles late; a muted slave is how a timeout is provoked
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dly <= 3'h0;
      slave_ack <= 1'b0;
    end
    else
    begin
      dly <= {dly[1:0], acc_start & ~mute};
      slave_ack <= dly[2];
    end
  end
endmodule // vxs_slave_model

/* File: test/vxs_ctrl_tb_top.sv */
// self-checking bench of the slot-0 bus, trigger and clock controller
`timescale 1ns/1ps
module vxs_ctrl_tb_top;
  import vxs_pkg::*;
  logic              clk, nrst, reg_wr, reg_rd, irq, mute, slot0, mst_need, mst_done;
  logic              acc_start, slave_ack, acc_berr, mst_owns, bbsy_in, bbsy_out;
  logic              clkgen_en, clk10_from_fp, clk10_drv_en, fp_clk_oe;
  logic [AW-1:0]     reg_addr;
  logic [DW-1:0]     reg_wdata, reg_rdata, v;
  logic [NREQ-1:0]   br_in, bg_out, seen, br_out;
  logic [NLINES-1:0] ttl_in, ttl_oe, lxi_in, lxi_out, lxi_oe, lxi_bias_en, ttl_out;
  int                fails, cmp_count, n, us;
  wire  [3:0]        csrc = {clkgen_en, clk10_from_fp, clk10_drv_en, fp_clk_oe};
  // two cycles per microsecond keeps the longest timeout short
  vxs_ctrl #(.TICK_CYC(2)) vxs_ctrl_i (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq, .mst_need, .mst_done, .acc_start, .slave_ack, .acc_berr,
    .mst_owns, .br_in, .bbsy_in, .br_out, .bbsy_out, .bg_out, .ttl_in, .ttl_out,
    .ttl_oe, .lxi_in, .lxi_out, .lxi_oe, .lxi_bias_en, .slot0, .clkgen_en,
    .clk10_from_fp, .clk10_drv_en, .fp_clk_oe);
  vxs_slave_model vxs_slave_model_i (.clk, .nrst, .acc_start, .mute, .slave_ack);
  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [AW-1:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask
  // one access, then count cycles until the error pulse, bounded
  task automatic go(input int lim);
    @(posedge clk);
    acc_start <= 1'b1;
    @(posedge clk);
    acc_start <= 1'b0;
    n = 0;
    while (acc_berr !== 1'b1 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic t_timer;
    rd(5'h1C);
    chk(v, RST_ZERO); // unmapped address reads zero
    go(100);
    chk(n, 100);
    @(posedge clk);
    mute <= 1'b1;
    for (int s = 0; s < 8; s++)
    begin
      us = (s == 6) ? 1025 : (16 << s);
      wr(REG_CFG, DW'(s));
      go(5000);
      chk(n >= 2 * us - 1 && n <= 2 * us + 3, 1);
    end
    repeat (3) @(negedge clk);
    chk(irq, 1'b0);
    rd(REG_IRQ_STAT);
    chk(v[0], 1'b1);
    wr(REG_IRQ_MASK, 32'h0000_0001);
    @(negedge clk);
    chk(irq, 1'b1);
    wr(REG_IRQ_STAT, 32'h0000_0001);
    @(negedge clk);
    chk(irq, 1'b0);
    $display("timer test done");
  endtask
  task automatic t_trig;
    @(posedge clk);
    ttl_in <= 8'hFE;
    lxi_in <= 8'h10;
    wr(REG_MAP, 32'h0000_A9AA);
    wr(REG_DRV, 32'h0000_0049);
    wr(REG_CTRL, 32'h0000_0802);
    repeat (3) @(negedge clk);
    chk(lxi_oe, 8'h09);
    chk({lxi_out[3], lxi_out[1:0]}, 3'h7);
    chk(lxi_bias_en, 8'h02);
    chk(ttl_oe, 8'h10);
    chk(ttl_out, 8'h00);
    @(posedge clk);
    ttl_in <= 8'hFC;
    repeat (3) @(negedge clk);
    chk(lxi_oe, 8'h0B);
    rd(REG_STATUS);
    chk(v, 32'h0000_0010);
    $display("trigger test done");
  endtask
  task automatic t_clk;
    wr(REG_CFG, 32'h0000_1000);
    repeat (2) @(negedge clk);
    chk(csrc, 4'h8);
    @(posedge clk);
    slot0 <= 1'b1;
    repeat (3) @(negedge clk);
    chk(csrc, 4'h6);
    wr(REG_CFG, RST_ZERO);
    repeat (2) @(negedge clk);
    chk(csrc, 4'hB);
    $display("clock test done");
  endtask
  task automatic t_arb;
    @(posedge clk);
    mst_need <= 1'b1;
    repeat (6) @(negedge clk);
    chk({mst_owns, bbsy_out}, 2'h3);
    @(posedge clk);
    br_in <= 4'h2;
    mst_need <= 1'b0;
    repeat (4) @(negedge clk);
    chk(mst_owns, 1'b0);
    for (int m = 0; m < 2; m++)
    begin
      wr(REG_CFG, DW'(m << 4));
      br_in <= 4'h3;
      seen = '0;
      repeat (6)
      begin
        @(negedge clk);
        seen = seen | bg_out;
      end
      chk(seen, m ? 4'h0 : 4'h2);
      @(posedge clk);
      br_in <= 4'h0;
      repeat (4) @(posedge clk);
    end
    // round robin with release when done: done drops ownership, request comes back
    wr(REG_CFG, 32'h0000_0220);
    mst_need <= 1'b1;
    repeat (6) @(negedge clk);
    chk(mst_owns, 1'b1);
    @(posedge clk);
    mst_done <= 1'b1;
    @(posedge clk);
    mst_done <= 1'b0;
    @(negedge clk);
    chk(mst_owns, 1'b0);
    chk(br_out, 4'h1);
    @(posedge clk);
    mst_need <= 1'b0;
    repeat (6) @(posedge clk);
    $display("arbiter test done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial
  begin
    {nrst, reg_wr, reg_rd, mute, slot0, mst_need, mst_done, acc_start, bbsy_in} = '0;
    {reg_addr, reg_wdata, br_in, ttl_in, lxi_in} = '0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_timer;
    t_trig;
    t_clk;
    t_arb;
    end_of_test;
  end
  // the run needs about 8400 cycles; cut a hang well past that
  initial
  begin
    #200us;
    fails++;
    end_of_test;
  end
endmodule // vxs_ctrl_tb_top
